/* File: rtl/power_button_pkg.sv */
/*
 * Shared constants and types for the power button and power-state
 * interrupt block: register addresses, field positions, reset values,
 * action encodings and timing figures.
 * Assumes a 40 MHz system clock and a 16-bit register port.
 */
package power_button_pkg;

   // Register addresses as seen on the register port.
   localparam logic [15:0] ADDR_BUTTON_CTRL  = 16'h4005;
   localparam logic [15:0] ADDR_IRQ_STAT_ONE = 16'h4011;
   localparam logic [15:0] ADDR_IRQ_STAT_TWO = 16'h4012;
   localparam logic [15:0] ADDR_IRQ_MASK_ONE = 16'h4019;
   localparam logic [15:0] ADDR_IRQ_MASK_TWO = 16'h401a;
   localparam logic [15:0] ADDR_CHARGE_CTRL  = 16'h4020;

   // Field positions in the button control register.
   localparam int TIMEOUT_LSB  = 0;
   localparam int LEVEL_BIT    = 3;
   localparam int FIRST_LSB    = 4;
   localparam int SECOND_LSB   = 8;

   // Flag positions.
   localparam int WAKE_BIT     = 0;
   localparam int SLEEP_OFF_BIT = 1;
   localparam int POR_BIT      = 2;
   localparam int BUTTON_BIT   = 12;
   localparam int CHG_BLOCK_BIT = 0;

   // Reset values.
   localparam logic [1:0] FIRST_RESET   = 2'h0;
   localparam logic [1:0] SECOND_RESET  = 2'h1;
   localparam logic [1:0] TIMEOUT_RESET = 2'h0;
   localparam logic [2:0] MASK_TWO_RESET = 3'h7;
   localparam logic       MASK_ONE_RESET = 1'b1;

   // Action field encodings.
   localparam logic [1:0] ACT_NONE_OR_IRQ = 2'h0;
   localparam logic [1:0] ACT_ON          = 2'h1;
   localparam logic [1:0] ACT_OFF         = 2'h2;

   // Timing: one slow tick is one millisecond.
   localparam int CLK_PERIOD_NS   = 25;
   localparam int TICK_NS         = 1000000;
   localparam int TICK_CYCLES     = (TICK_NS + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
   localparam int DEBOUNCE_MS     = 20;
   localparam int TIMEOUT_BASE_MS = 1000;
   localparam int HOLD_W          = 15;

   typedef enum logic [1:0] {
      PS_OFF,
      PS_ON,
      PS_SLEEP,
      PS_BACKUP
   } power_state_e;

   // Requests handed to the power state machine, one-cycle pulses.
   typedef struct packed {
      logic on_req;
      logic wake_req;
      logic off_req;
      logic src_button;
   } power_req_s;

endpackage : power_button_pkg

/* File: rtl/power_button_state_irq.sv */
/*
 * Power button press logic and power-state transition interrupt flags.
 * Assumes the power state, power-on reset level, charging status and
 * user-key unlock state come from neighbouring logic, all synchronous
 * to clk_sys, and that the button pin has its pull-up outside.
 */
// The implementer's own choice: the strobed register port.
// Behaviour
// - Entering SLEEP or OFF sets flag bit 1.
// - Entering ON sets flag bit 0.
// - Power-on reset rising edge sets bit 2.
// - Flags clear only on written one.
// - Unmasked power-state flags drive combined interrupt.
// - Mask bit one blocks; masks reset high.
// - ON indicator asserted while in ON.
// - SLEEP indicator asserted while in SLEEP.
// - Low-active button input is debounced first.
// - Press takes selected first action.
// - Every press sets button event flag.
// - Hold past timeout takes second action.
// - Timeout field selects 1, 2, 4, 8 s.
// - Further timeout requests OFF unless the charging block applies.
// - Charging block suppresses button OFF requests.
// - Level bit shows present button level.
// - Release also sets button event flag.
// - Button flag bit 12, masked by bit 12.
// - Locked key ignores control field writes.
// - Button ON wakes from SLEEP, marked button-sourced.

module power_button_state_irq
   import power_button_pkg::*;
#(
   parameter int TICK_LEN      = TICK_CYCLES,
   parameter int DEBOUNCE_LEN  = DEBOUNCE_MS,
   parameter int TIMEOUT_UNIT  = TIMEOUT_BASE_MS
) (
   // Clock and reset
   input  wire logic         clk_sys,
   input  wire logic         nrst,
   // Register port
   input  wire logic [15:0]  reg_addr,
   input  wire logic [15:0]  reg_wdata,
   input  wire logic         reg_wr,
   input  wire logic         reg_rd,
   output logic      [15:0]  reg_rdata,
   // Button pin, low while pressed
   input  wire logic         button_n,
   // Surrounding power logic
   input  power_state_e      power_state,
   input  wire logic         por_active,
   input  wire logic         charging_active,
   input  wire logic         user_key_unlocked,
   // Requests and interrupts
   output power_req_s        power_req,
   output logic              power_state_primary_irq,
   output logic              button_primary_irq,
   // Power state indication for general-purpose outputs
   output logic              gpio_on_state,
   output logic              gpio_sleep_state
);

   // Widths of the counters.
   localparam int TICK_W = $clog2(TICK_LEN + 1);
   localparam int DEB_W  = $clog2(DEBOUNCE_LEN + 1);

   // Hold time in ticks for a timeout code.
   function automatic logic [HOLD_W-1:0] timeout_ticks(
      input logic [1:0] sel
   );
      logic [HOLD_W-1:0] base;
      base = HOLD_W'(TIMEOUT_UNIT);
      return base << sel;
   endfunction : timeout_ticks

   // Register state.
   logic [1:0]        button_first_action_reg;
   logic [1:0]        button_second_action_reg;
   logic [1:0]        button_hold_timeout_reg;
   logic              charging_shutdown_block_reg;
   logic              button_event_flag_reg;
   logic              button_event_mask_reg;
   logic              wake_event_flag_reg;
   logic              sleep_or_off_event_flag_reg;
   logic              por_event_flag_reg;
   logic              wake_event_mask_reg;
   logic              sleep_or_off_event_mask_reg;
   logic              por_event_mask_reg;
   logic [15:0]       rdata_reg;

   // Block state.
   logic [TICK_W-1:0] tick_cnt_reg;
   logic [DEB_W-1:0]  deb_cnt_reg;
   logic              deb_level_reg;
   logic [HOLD_W-1:0] hold_cnt_reg;
   logic              second_done_reg;
   logic              third_done_reg;
   power_state_e      prev_state_reg;
   logic              prev_por_reg;
   power_req_s        power_req_reg;
   logic              gpio_on_reg;
   logic              gpio_sleep_reg;

   // Address decode and strobes.
   wire logic sel_ctrl   = reg_addr == ADDR_BUTTON_CTRL;
   wire logic sel_stat1  = reg_addr == ADDR_IRQ_STAT_ONE;
   wire logic sel_stat2  = reg_addr == ADDR_IRQ_STAT_TWO;
   wire logic sel_mask1  = reg_addr == ADDR_IRQ_MASK_ONE;
   wire logic sel_mask2  = reg_addr == ADDR_IRQ_MASK_TWO;
   wire logic sel_chg    = reg_addr == ADDR_CHARGE_CTRL;
   wire logic wr_ctrl    = reg_wr && sel_ctrl && user_key_unlocked;
   wire logic wr_stat1   = reg_wr && sel_stat1;
   wire logic wr_stat2   = reg_wr && sel_stat2;
   wire logic wr_mask1   = reg_wr && sel_mask1;
   wire logic wr_mask2   = reg_wr && sel_mask2;
   wire logic wr_chg     = reg_wr && sel_chg;

   // Slow tick.
   wire logic tick = tick_cnt_reg == TICK_W'(TICK_LEN - 1);
   wire logic [TICK_W-1:0] tick_next =
      tick ? '0 : tick_cnt_reg + TICK_W'(1);

   wire logic raw_differs = button_n != deb_level_reg;
   wire logic deb_done = raw_differs && tick &&
                         deb_cnt_reg == DEB_W'(DEBOUNCE_LEN - 1);
   wire logic [DEB_W-1:0] deb_next =
      !raw_differs ? '0 :
      deb_done     ? '0 :
      tick         ? deb_cnt_reg + DEB_W'(1) : deb_cnt_reg;
   wire logic press   = deb_done && !button_n;
   wire logic release_ev = deb_done && button_n;
   wire logic held    = !deb_level_reg;

   // Hold timing.
   wire logic [HOLD_W-1:0] period = timeout_ticks(button_hold_timeout_reg);
   wire logic second_fire = held && !second_done_reg &&
                            hold_cnt_reg == period;
   // fixed OFF after a further period
   wire logic third_fire = held && second_done_reg && !third_done_reg &&
                           hold_cnt_reg == period;
   // restart on press, saturate when done
   wire logic [HOLD_W-1:0] hold_next =
      (press || second_fire) ? '0 :
      (held && tick && !third_done_reg) ? hold_cnt_reg + HOLD_W'(1) :
      hold_cnt_reg;

   wire logic first_on  = press && button_first_action_reg == ACT_ON;
   wire logic first_off = press && button_first_action_reg == ACT_OFF;
   wire logic second_on  = second_fire &&
                           button_second_action_reg == ACT_ON;
   wire logic second_off = second_fire &&
                           button_second_action_reg == ACT_OFF;
   wire logic second_irq = second_fire &&
                           button_second_action_reg == ACT_NONE_OR_IRQ;
   wire logic want_on  = first_on || second_on;
   wire logic off_block = charging_shutdown_block_reg && charging_active;
   wire logic want_off = (first_off || second_off || third_fire) &&
                         !off_block;

   // ON from OFF, WAKE from SLEEP
   power_req_s req_next;
   assign req_next.on_req     = want_on && power_state == PS_OFF;
   assign req_next.wake_req   = want_on && power_state == PS_SLEEP;
   assign req_next.off_req    = want_off;
   assign req_next.src_button = req_next.on_req || req_next.wake_req;

   wire logic button_set = press || release_ev || second_irq;
   // set wins over a written one
   wire logic button_flag_next =
      button_set ||
      (button_event_flag_reg && !(wr_stat1 && reg_wdata[BUTTON_BIT]));

   wire logic wake_set = power_state == PS_ON && prev_state_reg != PS_ON;
   wire logic sleep_off_set =
      (power_state == PS_SLEEP && prev_state_reg != PS_SLEEP) ||
      (power_state == PS_OFF && prev_state_reg != PS_OFF);
   wire logic por_set = por_active && !prev_por_reg;

   wire logic wake_flag_next = wake_set ||
      (wake_event_flag_reg && !(wr_stat2 && reg_wdata[WAKE_BIT]));
   wire logic sleep_off_flag_next = sleep_off_set ||
      (sleep_or_off_event_flag_reg &&
       !(wr_stat2 && reg_wdata[SLEEP_OFF_BIT]));
   wire logic por_flag_next = por_set ||
      (por_event_flag_reg && !(wr_stat2 && reg_wdata[POR_BIT]));

   // Read mux.
   logic [15:0] ctrl_view;
   logic [15:0] stat1_view;
   logic [15:0] stat2_view;
   logic [15:0] mask1_view;
   logic [15:0] mask2_view;
   logic [15:0] chg_view;
   logic [15:0] rd_mux;
   always_comb begin
      ctrl_view = '0;
      ctrl_view[SECOND_LSB +: 2]  = button_second_action_reg;
      ctrl_view[FIRST_LSB +: 2]   = button_first_action_reg;
      ctrl_view[LEVEL_BIT]        = button_n;
      ctrl_view[TIMEOUT_LSB +: 2] = button_hold_timeout_reg;
      stat1_view = '0;
      stat1_view[BUTTON_BIT] = button_event_flag_reg;
      mask1_view = '0;
      mask1_view[BUTTON_BIT] = button_event_mask_reg;
      stat2_view = '0;
      stat2_view[WAKE_BIT]      = wake_event_flag_reg;
      stat2_view[SLEEP_OFF_BIT] = sleep_or_off_event_flag_reg;
      stat2_view[POR_BIT]       = por_event_flag_reg;
      mask2_view = '0;
      mask2_view[WAKE_BIT]      = wake_event_mask_reg;
      mask2_view[SLEEP_OFF_BIT] = sleep_or_off_event_mask_reg;
      mask2_view[POR_BIT]       = por_event_mask_reg;
      chg_view = '0;
      chg_view[CHG_BLOCK_BIT] = charging_shutdown_block_reg;
      rd_mux = sel_ctrl  ? ctrl_view  :
               sel_stat1 ? stat1_view :
               sel_stat2 ? stat2_view :
               sel_mask1 ? mask1_view :
               sel_mask2 ? mask2_view :
               sel_chg   ? chg_view   : '0;
   end

   // Registers written by software.
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         button_first_action_reg     <= FIRST_RESET;
         button_second_action_reg    <= SECOND_RESET;
         button_hold_timeout_reg     <= TIMEOUT_RESET;
         charging_shutdown_block_reg <= 1'b0;
         button_event_mask_reg       <= MASK_ONE_RESET;
         {por_event_mask_reg, sleep_or_off_event_mask_reg,
          wake_event_mask_reg}       <= MASK_TWO_RESET;
      end else begin
         if (wr_ctrl) begin
            button_first_action_reg  <= reg_wdata[FIRST_LSB +: 2];
            button_second_action_reg <= reg_wdata[SECOND_LSB +: 2];
            button_hold_timeout_reg  <= reg_wdata[TIMEOUT_LSB +: 2];
         end
         if (wr_chg) begin
            charging_shutdown_block_reg <= reg_wdata[CHG_BLOCK_BIT];
         end
         if (wr_mask1) begin
            button_event_mask_reg <= reg_wdata[BUTTON_BIT];
         end
         if (wr_mask2) begin
            wake_event_mask_reg         <= reg_wdata[WAKE_BIT];
            sleep_or_off_event_mask_reg <= reg_wdata[SLEEP_OFF_BIT];
            por_event_mask_reg          <= reg_wdata[POR_BIT];
         end
      end
   end

   // Flags, edge history and read data.
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         button_event_flag_reg       <= 1'b0;
         wake_event_flag_reg         <= 1'b0;
         sleep_or_off_event_flag_reg <= 1'b0;
         por_event_flag_reg          <= 1'b0;
         prev_state_reg              <= PS_OFF;
         prev_por_reg                <= 1'b0;
         rdata_reg                   <= '0;
      end else begin
         button_event_flag_reg       <= button_flag_next;
         wake_event_flag_reg         <= wake_flag_next;
         sleep_or_off_event_flag_reg <= sleep_off_flag_next;
         por_event_flag_reg          <= por_flag_next;
         prev_state_reg              <= power_state;
         prev_por_reg                <= por_active;
         rdata_reg                   <= reg_rd ? rd_mux : '0;
      end
   end

   // Button timing and requests.
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         tick_cnt_reg    <= '0;
         deb_cnt_reg     <= '0;
         deb_level_reg   <= 1'b1;
         hold_cnt_reg    <= '0;
         second_done_reg <= 1'b0;
         third_done_reg  <= 1'b0;
         power_req_reg   <= '0;
      end else begin
         tick_cnt_reg  <= tick_next;
         deb_cnt_reg   <= deb_next;
         if (deb_done) begin
            deb_level_reg <= button_n;
         end
         hold_cnt_reg  <= hold_next;
         if (press) begin
            second_done_reg <= 1'b0;
            third_done_reg  <= 1'b0;
         end else begin
            second_done_reg <= second_done_reg || second_fire;
            third_done_reg  <= third_done_reg || third_fire;
         end
         power_req_reg <= req_next;
      end
   end

   // State indication outputs.
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         gpio_on_reg    <= 1'b0;
         gpio_sleep_reg <= 1'b0;
      end else begin
         gpio_on_reg    <= power_state == PS_ON;
         gpio_sleep_reg <= power_state == PS_SLEEP;
      end
   end

   assign reg_rdata        = rdata_reg;
   assign power_req        = power_req_reg;
   assign gpio_on_state    = gpio_on_reg;
   assign gpio_sleep_state = gpio_sleep_reg;
   assign power_state_primary_irq =
      (wake_event_flag_reg && !wake_event_mask_reg) ||
      (sleep_or_off_event_flag_reg && !sleep_or_off_event_mask_reg) ||
      (por_event_flag_reg && !por_event_mask_reg);
   assign button_primary_irq = button_event_flag_reg &&
                               !button_event_mask_reg;

endmodule : power_button_state_irq

/* File: testbench/power_button_state_irq_asserts.sv */
/* Port assertions for the power button and power-state block.
   Assumes one clk_sys domain with synchronous active-low nrst. */
module power_button_state_irq_asserts
   import power_button_pkg::*;
(
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        nrst,
   // Register port
   input wire logic [15:0] reg_addr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   // Pins and requests
   input wire logic        button_n,
   input power_state_e     power_state,
   input power_req_s       power_req,
   input wire logic        gpio_on_state,
   input wire logic        gpio_sleep_state
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   wire logic any_req = power_req.on_req | power_req.wake_req
                        | power_req.off_req;

   sequence ctrl_read;
      reg_rd && reg_addr == ADDR_BUTTON_CTRL;
   endsequence
   sequence pulse_ends;
      ##1 !any_req;
   endsequence

   gpio_on_a: assert property (
      $past(nrst) |-> gpio_on_state == ($past(power_state) == PS_ON))
      else $error("on indicator wrong");
   gpio_sleep_a: assert property (
      $past(nrst) |-> gpio_sleep_state == ($past(power_state) == PS_SLEEP))
      else $error("sleep indicator wrong");
   req_once_a: assert property (any_req |-> pulse_ends)
      else $error("request longer than one cycle");
   src_pair_a: assert property (
      power_req.src_button == (power_req.on_req || power_req.wake_req))
      else $error("source mark wrong");
   on_from_off_a: assert property (
      power_req.on_req |-> $past(power_state) == PS_OFF)
      else $error("on request outside off");
   wake_from_sleep_a: assert property (
      power_req.wake_req |-> $past(power_state) == PS_SLEEP)
      else $error("wake request outside sleep");
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data outside read cycle");
   level_read_a: assert property (
      ctrl_read |=> reg_rdata[LEVEL_BIT] == $past(button_n))
      else $error("level bit wrong");
   req_held_a: assert property (
      any_req |-> $past(button_n) == 1'b0 && $past(button_n, 5) == 1'b0)
      else $error("request without steady press");
endmodule : power_button_state_irq_asserts

bind power_button_state_irq power_button_state_irq_asserts chk (
   .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .button_n(button_n), .power_state(power_state),
   .power_req(power_req), .gpio_on_state(gpio_on_state),
   .gpio_sleep_state(gpio_sleep_state));

/* File: testbench/push_switch.sv */
/* Push switch to ground with pull-up and contact bounce.
   Assumes the bench moves the contact command after clock edges. */
module push_switch (
   // Clock
   input wire logic clk_sys,
   // Contact command, high while closed
   input wire logic closed,
   // Switch pin
   output logic     button_n
);
   timeunit 1ns;
   timeprecision 100ps;
   logic       state_reg;
   logic [1:0] bounce_reg;
   initial begin
      button_n = 1'b1;
      state_reg = 1'b0;
      bounce_reg = 2'h0;
   end
   always @(posedge clk_sys) begin
      if (closed != state_reg) begin
         state_reg <= closed;
         bounce_reg <= 2'h3;
      end else if (bounce_reg != 2'h0) begin
         bounce_reg <= bounce_reg - 2'h1;
         button_n <= ~button_n;
      end else begin
         button_n <= ~state_reg;
      end
   end
endmodule : push_switch

/* File: testbench/test_power_button_state_irq.sv */
/* Self-checking bench for the power button and power-state block.
   Assumes small timing parameters: 4-cycle tick, 2-tick debounce. */
module test_power_button_state_irq
   import power_button_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam power_req_s REQ_ON = 4'b1001;
   localparam power_req_s REQ_WAKE = 4'b0101;
   localparam power_req_s REQ_OFF = 4'b0010;
   logic clk_sys, nrst, reg_wr, reg_rd, closed, button_n, rd_seen;
   logic [15:0] reg_addr, reg_wdata, reg_rdata, ctrl_v;
   logic por_active, charging_active, user_key_unlocked;
   logic power_state_primary_irq, button_primary_irq;
   logic gpio_on_state, gpio_sleep_state;
   power_state_e power_state;
   power_req_s power_req;
   logic [15:0] rd_q[$];
   power_req_s req_q[$];
   int errors = 0;
   int tests_run = 0;

   power_button_state_irq #(.TICK_LEN(4), .DEBOUNCE_LEN(2),
      .TIMEOUT_UNIT(10)) uut (.clk_sys(clk_sys), .nrst(nrst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .button_n(button_n),
      .power_state(power_state), .por_active(por_active),
      .charging_active(charging_active),
      .user_key_unlocked(user_key_unlocked), .power_req(power_req),
      .power_state_primary_irq(power_state_primary_irq),
      .button_primary_irq(button_primary_irq),
      .gpio_on_state(gpio_on_state), .gpio_sleep_state(gpio_sleep_state));
   push_switch sw (.clk_sys(clk_sys), .closed(closed), .button_n(button_n));

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   task automatic bad(input string m);
      errors++;
      $display("unexpected at %0t: %s", $time, m);
   endtask : bad
   task automatic cmp_rd(input logic [15:0] got, exp);
      tests_run++;
      if (got !== exp) bad($sformatf("read %h not %h", got, exp));
   endtask : cmp_rd
   task automatic cmp_req(input power_req_s got, exp);
      tests_run++;
      if (got !== exp) bad($sformatf("request %b not %b", got, exp));
   endtask : cmp_req
   task automatic cmp_pin(input logic got, exp);
      tests_run++;
      if (got !== exp) bad($sformatf("pin %b not %b", got, exp));
   endtask : cmp_pin
   task automatic finish_test();
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : finish_test

   // Results are matched against the oldest note in each queue.
   always @(posedge clk_sys) rd_seen <= reg_rd;
   always @(negedge clk_sys) begin
      if (rd_seen && rd_q.size() == 0) bad("read without a note");
      else if (rd_seen) cmp_rd(reg_rdata, rd_q.pop_front());
      if (nrst && power_req !== '0) begin
         cmp_req(power_req, req_q.size() ? req_q.pop_front() : '0);
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : cyc
   task automatic wr(input logic [15:0] a, d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, e);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      rd_q.push_back(e);
      @(posedge clk_sys);
      reg_rd <= 1'b0;
   endtask : rd
   task automatic step(input power_state_e s, input logic p,
                       input logic [15:0] e);
      power_state <= s;
      por_active <= p;
      cyc(3);
      cmp_pin(gpio_on_state, s == PS_ON);
      cmp_pin(gpio_sleep_state, s == PS_SLEEP);
      rd(ADDR_IRQ_STAT_TWO, e);
      cmp_pin(power_state_primary_irq, 1'b1);
      wr(ADDR_IRQ_STAT_TWO, ~e);
      rd(ADDR_IRQ_STAT_TWO, e);
      wr(ADDR_IRQ_STAT_TWO, e);
      rd(ADDR_IRQ_STAT_TWO, 16'h0000);
      cmp_pin(power_state_primary_irq, 1'b0);
   endtask : step
   task automatic setup(input logic [1:0] t, f, s);
      ctrl_v = {6'h00, s, 2'h0, f, 2'h0, t};
      wr(ADDR_BUTTON_CTRL, ctrl_v);
      rd(ADDR_BUTTON_CTRL, ctrl_v | 16'h0008);
   endtask : setup
   // The press flag is cleared early so that a later set by the
   // second action shows up on its own in the late read.
   task automatic push(input int hold, input logic [15:0] late);
      @(posedge clk_sys);
      closed <= 1'b1;
      cyc(20);
      rd(ADDR_IRQ_STAT_ONE, 16'h1000);
      cmp_pin(button_primary_irq, 1'b1);
      wr(ADDR_IRQ_STAT_ONE, 16'h1000);
      cyc(hold);
      rd(ADDR_BUTTON_CTRL, ctrl_v);
      rd(ADDR_IRQ_STAT_ONE, late);
      wr(ADDR_IRQ_STAT_ONE, 16'h1000);
      rd(ADDR_IRQ_STAT_ONE, 16'h0000);
      closed <= 1'b0;
      cyc(20);
      rd(ADDR_IRQ_STAT_ONE, 16'h1000);
      wr(ADDR_IRQ_STAT_ONE, 16'h1000);
   endtask : push

   initial begin
      logic [1:0] t;
      {nrst, reg_wr, reg_rd, closed, por_active} = '0;
      {charging_active, user_key_unlocked, reg_addr, reg_wdata} = '0;
      power_state = PS_OFF;
      void'($urandom(40));
      cyc(10);
      nrst <= 1'b1;
      rd(ADDR_BUTTON_CTRL, 16'h0108);
      rd(ADDR_IRQ_MASK_ONE, 16'h1000);
      rd(ADDR_IRQ_MASK_TWO, 16'h0007);
      rd(16'h4030, 16'h0000);
      wr(ADDR_BUTTON_CTRL, 16'h0213);
      rd(ADDR_BUTTON_CTRL, 16'h0108);
      wr(ADDR_IRQ_MASK_TWO, 16'h0000);
      step(PS_ON, 1'b0, 16'h0001);
      step(PS_SLEEP, 1'b0, 16'h0002);
      step(PS_OFF, 1'b0, 16'h0002);
      step(PS_OFF, 1'b1, 16'h0004);
      power_state <= PS_BACKUP;
      cyc(3);
      cmp_pin(gpio_on_state || gpio_sleep_state, 1'b0);
      rd(ADDR_IRQ_STAT_TWO, 16'h0000);
      cmp_pin(power_state_primary_irq, 1'b0);
      wr(ADDR_IRQ_MASK_TWO, 16'h0007);
      power_state <= PS_SLEEP;
      cyc(3);
      cmp_pin(power_state_primary_irq, 1'b0);
      rd(ADDR_IRQ_STAT_TWO, 16'h0002);
      wr(ADDR_IRQ_STAT_TWO, 16'h0002);
      user_key_unlocked <= 1'b1;
      wr(ADDR_IRQ_MASK_ONE, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         setup(2'h0, i[1:0], 2'h1);
         if (i == 1) req_q.push_back(REQ_WAKE);
         if (i == 2) req_q.push_back(REQ_OFF);
         push(0, 16'h0000);
      end
      power_state <= PS_OFF;
      for (int i = 0; i < 3; i++) begin
         t = 2'($urandom_range(3, 0));
         setup(t, 2'h0, i[1:0]);
         if (i == 1) req_q.push_back(REQ_ON);
         if (i == 2) req_q.push_back(REQ_OFF);
         req_q.push_back(REQ_OFF);
         push((80 << t) + 10, i == 0 ? 16'h1000 : 16'h0000);
      end
      wr(ADDR_CHARGE_CTRL, 16'h0001);
      charging_active <= 1'b1;
      setup(2'h0, 2'h2, 2'h2);
      push(90, 16'h0000);
      charging_active <= 1'b0;
      req_q.push_back(REQ_OFF);
      push(0, 16'h0000);
      cyc(5);
      cmp_pin(req_q.size() == 0 && rd_q.size() == 0, 1'b1);
      finish_test();
   end

   initial begin
      cyc(20000);
      bad("timeout");
      finish_test();
   end
endmodule : test_power_button_state_irq
